// File: vbad_pkg.sv
// Constants and types shared by the base address decoder files
package vbad_pkg;

    // ------------------------------------------------------------
    // Window geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int OFFS_W = 24;
    localparam logic [23:0] OFFS_MASK = 24'hffffff;
    localparam int SW_HI_MSB = 31;
    localparam int SW_HI_LSB = 28;
    localparam int SW_LO_MSB = 27;
    localparam int SW_LO_LSB = 24;
    localparam int GEO_MSB = 28;
    localparam int GEO_LSB = 24;
    localparam logic [31:0] FACTORY_BASE = 32'h38000000;

    // ------------------------------------------------------------
    // Address modifiers that mark an A32 access
    // ------------------------------------------------------------
    localparam logic [5:0] AM_A32_MBLT_U = 6'h08;
    localparam logic [5:0] AM_A32_DATA_U = 6'h09;
    localparam logic [5:0] AM_A32_PROG_U = 6'h0a;
    localparam logic [5:0] AM_A32_BLT_U = 6'h0b;
    localparam logic [5:0] AM_A32_MBLT_S = 6'h0c;
    localparam logic [5:0] AM_A32_DATA_S = 6'h0d;
    localparam logic [5:0] AM_A32_PROG_S = 6'h0e;
    localparam logic [5:0] AM_A32_BLT_S = 6'h0f;

    // ------------------------------------------------------------
    // Key addresses
    // ------------------------------------------------------------
    localparam int KEY_N = 12;
    localparam logic [23:0] KEY_FIRST = 24'h000400;
    localparam logic [23:0] KEY_LAST = 24'h00042c;

    // ------------------------------------------------------------
    // Avalon register byte offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [7:0] REG_LAST_ADDR = 8'h08;
    localparam logic [7:0] REG_HIT_COUNT = 8'h0c;
    localparam logic [7:0] REG_KEY_SEEN = 8'h10;
    localparam logic [31:0] CONTROL_RST = 32'h00000001;
    localparam int CTL_ENABLE = 0;

    typedef enum {
        VBAD_IDLE,
        VBAD_LOCAL,
        VBAD_ACK,
        VBAD_SKIP
    } vbad_state_t;

endpackage

// File: vbad_sync.sv
// Two-stage synchroniser for backplane and jumper inputs
`timescale 1ns/100ps
module vbad_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Asynchronous level in, synchronous level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } vbad_sync_t;

    vbad_sync_t st_ff;
    vbad_sync_t nxt_st;

    always_comb
    begin
        nxt_st.meta = async_in;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_ff.meta <= RST_VAL;
            st_ff.stable <= RST_VAL;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;

endmodule

// File: vbad_decoder.sv
// Backplane base address decoder with Avalon-MM status and control
//
// Contract
// R1: Only A32 cycles are claimed, in one 16 MByte window, low 24 bits are the offset.
// R2: With the wide addressing jumper open nothing is decoded in any mode.
// R3: Wide jumper closed and slot jumper open compares against the rotary switches.
// R4: Both jumpers closed compares against the backplane geographical address.
// R5: Switch mode matches bits 31..28 to the high switch and 27..24 to the low one.
// R6: Slot mode matches bits 28..24 to the geographical lines, 31..29 are ignored.
// R7: A jumper reads 0 when open and 1 when closed.
// R8: The size jumper reports 64 MByte when open and 512 MByte when closed.
// R9: Factory setting switches 3 and 8, wide closed, slot open, gives 0x38000000.
// R10: Switch mode uses no geographical backplane signal at all.
// R11: A write of any data to a key address fires its action and stores nothing.
// R12: The cycle is answered only for an A32 modifier and a matching base.
`timescale 1ns/100ps
module vbad_decoder (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Backplane cycle inputs
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_as_n,
    input wire logic vme_ds_n,
    input wire logic vme_write_n,
    input wire logic [4:0] vme_ga_n,
    // Backplane data and acknowledge, open drain style
    input wire logic [31:0] vme_data_i,
    output logic [31:0] vme_data_o,
    output logic vme_data_oe_n,
    output logic vme_dtack_o,
    output logic vme_dtack_oe_n,
    // Board straps
    input wire logic wide_addressing_jumper,
    input wire logic slot_addressing_jumper,
    input wire logic mem_size_jumper,
    input wire logic [3:0] high_nibble_rotary_switch,
    input wire logic [3:0] low_nibble_rotary_switch,
    // Local side towards the internal register map
    output logic local_start,
    output logic local_write,
    output logic [23:0] local_offset,
    output logic [31:0] local_wdata,
    input wire logic local_done,
    input wire logic [31:0] local_rdata,
    output logic [11:0] key_pulse,
    output logic mem_512mb,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int SYNC_W = 94;
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] syn;
    logic [31:0] vme_data_i_s;
    logic [31:0] s_addr;
    logic [5:0] s_am;
    logic s_as_n;
    logic s_ds_n;
    logic s_write_n;
    logic [4:0] s_ga;
    logic s_wide;
    logic s_slot;
    logic s_size;
    logic [3:0] s_sw_hi;
    logic [3:0] s_sw_lo;

    // Strobes idle high so no cycle is seen during reset
    localparam logic [SYNC_W-1:0] SYNC_RST = {32'h00000000, 32'h00000000,
        6'h00, 3'h7, 5'h1f, 3'h0, 8'h00, 5'h00};

    assign raw_in = {vme_data_i, vme_addr, vme_am, vme_as_n, vme_ds_n,
        vme_write_n, vme_ga_n, wide_addressing_jumper, slot_addressing_jumper,
        mem_size_jumper, high_nibble_rotary_switch,
        low_nibble_rotary_switch, 5'h00};

    vbad_sync #(
        .WIDTH(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign vme_data_i_s = syn[93:62];
    assign s_addr = syn[61:30];
    assign s_am = syn[29:24];
    assign s_as_n = syn[23];
    assign s_ds_n = syn[22];
    assign s_write_n = syn[21];
    // Geographical lines are active low on the backplane
    assign s_ga = ~syn[20:16];
    // Closed jumper pulls the pin high, so it reads as 1
    assign s_wide = syn[15]; // R7
    assign s_slot = syn[14]; // R7
    assign s_size = syn[13]; // R7
    assign s_sw_hi = syn[12:9];
    assign s_sw_lo = syn[8:5];

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_a32_am(input logic [5:0] am);
        case (am)
            vbad_pkg::AM_A32_MBLT_U,
            vbad_pkg::AM_A32_DATA_U,
            vbad_pkg::AM_A32_PROG_U,
            vbad_pkg::AM_A32_BLT_U,
            vbad_pkg::AM_A32_MBLT_S,
            vbad_pkg::AM_A32_DATA_S,
            vbad_pkg::AM_A32_PROG_S,
            vbad_pkg::AM_A32_BLT_S: is_a32_am = 1'b1; // R1
            default: is_a32_am = 1'b0;
        endcase
    endfunction

    function automatic logic is_key(input logic [23:0] offs);
        is_key = offs >= vbad_pkg::KEY_FIRST && offs <= vbad_pkg::KEY_LAST &&
            offs[1:0] == 2'b00;
    endfunction

    function automatic logic [11:0] key_onehot(input logic [23:0] offs);
        logic [23:0] idx;
        idx = (offs - vbad_pkg::KEY_FIRST) >> 2;
        key_onehot = 12'h001 << idx[3:0];
    endfunction

    // ------------------------------------------------------------
    // Base address compare
    // ------------------------------------------------------------
    logic sw_match;
    logic geo_match;
    logic base_match;
    logic a32_ok;

    // Rotary switches only, no geographical backplane lines involved
    assign sw_match = s_addr[vbad_pkg::SW_HI_MSB:vbad_pkg::SW_HI_LSB]
        == s_sw_hi && // R5 R10
        s_addr[vbad_pkg::SW_LO_MSB:vbad_pkg::SW_LO_LSB] == s_sw_lo; // R5
    // Top three bits are don't care in slot mode
    assign geo_match = s_addr[vbad_pkg::GEO_MSB:vbad_pkg::GEO_LSB]
        == s_ga; // R6

    always_comb
    begin
        case ({s_wide, s_slot})
            2'b10: base_match = sw_match; // R3
            2'b11: base_match = geo_match; // R4
            default: base_match = 1'b0; // R2
        endcase
    end

    assign a32_ok = is_a32_am(s_am); // R1

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        vbad_pkg::vbad_state_t state;
        logic [23:0] offset;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic start;
        logic [11:0] key;
        logic dtack;
        logic drive;
        logic [31:0] control;
        logic [31:0] last_addr;
        logic [31:0] hits;
        logic [11:0] key_seen;
        logic av_ack;
        logic [31:0] av_rdata;
    } vbad_st_t;

    vbad_st_t st_ff;
    vbad_st_t nxt_st;

    logic av_req;
    logic [31:0] be_mask;
    logic [11:0] key_hit;
    logic [31:0] status_word;

    assign av_req = avs_read | avs_write;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign status_word = {20'h00000, st_ff.state == vbad_pkg::VBAD_IDLE,
        s_size, s_slot, s_wide, s_sw_hi, s_sw_lo};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.start = 1'b0;
        nxt_st.key = 12'h000;
        key_hit = 12'h000;

        case (st_ff.state)
            vbad_pkg::VBAD_IDLE:
            begin
                nxt_st.dtack = 1'b0;
                nxt_st.drive = 1'b0;
                if (!s_as_n && !s_ds_n)
                begin
                    // Foreign cycles are left alone until strobes drop
                    if (a32_ok && base_match &&
                        st_ff.control[vbad_pkg::CTL_ENABLE]) // R12
                    begin
                        nxt_st.offset = s_addr[23:0] &
                            vbad_pkg::OFFS_MASK; // R1
                        nxt_st.wr = !s_write_n;
                        nxt_st.wdata = vme_data_i_s;
                        nxt_st.last_addr = s_addr;
                        nxt_st.hits = st_ff.hits + 32'h00000001;
                        if (!s_write_n && is_key(s_addr[23:0]))
                        begin
                            // Data is ignored, only the action fires
                            key_hit = key_onehot(s_addr[23:0]); // R11
                            nxt_st.key = key_hit;
                            nxt_st.dtack = 1'b1;
                            nxt_st.state = vbad_pkg::VBAD_ACK;
                        end
                        else
                        begin
                            nxt_st.start = 1'b1;
                            nxt_st.state = vbad_pkg::VBAD_LOCAL;
                        end
                    end
                    else
                    begin
                        nxt_st.state = vbad_pkg::VBAD_SKIP; // R12
                    end
                end
            end
            vbad_pkg::VBAD_LOCAL:
            begin
                if (local_done)
                begin
                    nxt_st.rdata = local_rdata;
                    nxt_st.drive = !st_ff.wr;
                    nxt_st.dtack = 1'b1;
                    nxt_st.state = vbad_pkg::VBAD_ACK;
                end
            end
            vbad_pkg::VBAD_ACK:
            begin
                if (s_ds_n)
                begin
                    nxt_st.dtack = 1'b0;
                    nxt_st.drive = 1'b0;
                    nxt_st.state = s_as_n ? vbad_pkg::VBAD_IDLE :
                        vbad_pkg::VBAD_SKIP;
                end
            end
            vbad_pkg::VBAD_SKIP:
            begin
                if (s_as_n)
                begin
                    nxt_st.state = vbad_pkg::VBAD_IDLE;
                end
            end
            default:
            begin
                nxt_st.state = vbad_pkg::VBAD_IDLE;
                nxt_st.dtack = 1'b0;
                nxt_st.drive = 1'b0;
            end
        endcase

        // Avalon slave: one wait state, answer on the second edge
        nxt_st.av_ack = av_req && !st_ff.av_ack;
        if (av_req && !st_ff.av_ack)
        begin
            case (avs_address)
                vbad_pkg::REG_STATUS: nxt_st.av_rdata = status_word;
                vbad_pkg::REG_CONTROL: nxt_st.av_rdata = st_ff.control;
                vbad_pkg::REG_LAST_ADDR: nxt_st.av_rdata = st_ff.last_addr;
                vbad_pkg::REG_HIT_COUNT: nxt_st.av_rdata = st_ff.hits;
                vbad_pkg::REG_KEY_SEEN:
                    nxt_st.av_rdata = {20'h00000, st_ff.key_seen};
                default: nxt_st.av_rdata = 32'h00000000;
            endcase
        end

        if (avs_write && st_ff.av_ack)
        begin
            case (avs_address)
                vbad_pkg::REG_CONTROL:
                    nxt_st.control = (st_ff.control & ~be_mask) |
                        (avs_writedata & be_mask);
                vbad_pkg::REG_HIT_COUNT:
                    nxt_st.hits = 32'h00000000;
                vbad_pkg::REG_KEY_SEEN:
                    nxt_st.key_seen = st_ff.key_seen &
                        ~(avs_writedata[11:0] & be_mask[11:0]);
                default: nxt_st.key_seen = st_ff.key_seen;
            endcase
        end
        // New key hits win over a clear in the same cycle
        nxt_st.key_seen = nxt_st.key_seen | key_hit;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_ff.state <= vbad_pkg::VBAD_IDLE;
            st_ff.offset <= 24'h000000;
            st_ff.wr <= 1'b0;
            st_ff.wdata <= 32'h00000000;
            st_ff.rdata <= 32'h00000000;
            st_ff.start <= 1'b0;
            st_ff.key <= 12'h000;
            st_ff.dtack <= 1'b0;
            st_ff.drive <= 1'b0;
            st_ff.control <= vbad_pkg::CONTROL_RST;
            st_ff.last_addr <= vbad_pkg::FACTORY_BASE; // R9
            st_ff.hits <= 32'h00000000;
            st_ff.key_seen <= 12'h000;
            st_ff.av_ack <= 1'b0;
            st_ff.av_rdata <= 32'h00000000;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign vme_data_o = st_ff.rdata;
    assign vme_data_oe_n = !st_ff.drive;
    assign vme_dtack_o = 1'b0;
    assign vme_dtack_oe_n = !st_ff.dtack; // R12
    assign local_start = st_ff.start;
    assign local_write = st_ff.wr;
    assign local_offset = st_ff.offset;
    assign local_wdata = st_ff.wdata;
    assign key_pulse = st_ff.key; // R11
    assign mem_512mb = s_size; // R8
    assign avs_readdata = st_ff.av_rdata;
    assign avs_waitrequest = av_req && !st_ff.av_ack;

endmodule

// File: vbad_decoder_note_unused.sv
// Spare file, no logic

// File: vbad_decoder_properties.sv
// Port checker for the base address decoder
`timescale 1ns/100ps
module vbad_decoder_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Backplane side
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_ds_n,
    input wire logic [4:0] vme_ga_n,
    input wire logic vme_data_oe_n,
    input wire logic vme_dtack_oe_n,
    // Straps
    input wire logic wide_addressing_jumper,
    input wire logic slot_addressing_jumper,
    input wire logic mem_size_jumper,
    input wire logic [3:0] high_nibble_rotary_switch,
    input wire logic [3:0] low_nibble_rotary_switch,
    // Local side
    input wire logic local_start,
    input wire logic [11:0] key_pulse,
    input wire logic mem_512mb
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Four cycles cover synchroniser and decode
    wire logic quiet = !local_start && key_pulse == 12'h000;
    wire logic sw_miss = wide_addressing_jumper && !slot_addressing_jumper
        && vme_addr[31:24] != {high_nibble_rotary_switch,
        low_nibble_rotary_switch};
    wire logic geo_miss = wide_addressing_jumper && slot_addressing_jumper
        && vme_addr[28:24] != ~vme_ga_n;
    property p_key_onehot; $onehot0(key_pulse); endproperty
    a_key_onehot: assert property (p_key_onehot)
        else $error("several key pulses at once");
    property p_key_once; key_pulse != 12'h000 |=> key_pulse == 12'h000;
    endproperty
    a_key_once: assert property (p_key_once)
        else $error("key pulse too long");
    property p_key_ack; key_pulse != 12'h000 |->
        !vme_dtack_oe_n && !local_start; endproperty
    a_key_ack: assert property (p_key_ack)
        else $error("key write ack wrong");
    property p_start_once; local_start |=> !local_start; endproperty
    a_start_once: assert property (p_start_once)
        else $error("start pulse too long");
    property p_wide_off; !wide_addressing_jumper [*4] |-> quiet; endproperty
    a_wide_off: assert property (p_wide_off)
        else $error("claimed with wide open");
    property p_am; (vme_am[5:3] != 3'b001) [*4] |-> quiet; endproperty
    a_am: assert property (p_am)
        else $error("claimed non A32 cycle");
    property p_sw; sw_miss [*4] |-> quiet; endproperty
    a_sw: assert property (p_sw)
        else $error("claimed on switch miss");
    property p_geo; geo_miss [*4] |-> quiet; endproperty
    a_geo: assert property (p_geo)
        else $error("claimed on slot miss");
    property p_size; $stable(mem_size_jumper) [*3] |->
        mem_512mb == mem_size_jumper; endproperty
    a_size: assert property (p_size)
        else $error("size flag wrong");
    property p_release; vme_ds_n [*4] |-> vme_dtack_oe_n && vme_data_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("bus held after release");
endmodule
bind vbad_decoder vbad_decoder_properties vbad_decoder_properties_i (
    .mclk, .reset, .vme_addr, .vme_am, .vme_ds_n, .vme_ga_n, .vme_data_oe_n,
    .vme_dtack_oe_n, .wide_addressing_jumper, .slot_addressing_jumper,
    .mem_size_jumper, .high_nibble_rotary_switch, .low_nibble_rotary_switch,
    .local_start, .key_pulse, .mem_512mb);

// File: vbad_vme_master.sv
// Backplane master model issuing single D32 cycles
`timescale 1ns/100ps
module vbad_vme_master (
    // Clock
    input wire logic mclk,
    // Cycle towards the decoder
    output logic [31:0] vme_addr,
    output logic [5:0] vme_am,
    output logic vme_as_n,
    output logic vme_ds_n,
    output logic vme_write_n,
    output logic [31:0] vme_data_i,
    // Answer from the decoder
    input wire logic [31:0] vme_data_o,
    input wire logic vme_data_oe_n,
    input wire logic vme_dtack_o,
    input wire logic vme_dtack_oe_n
);
    // Acknowledge pulled up; undriven data toggles
    logic [31:0] noise = 32'h5a5aa5a5;
    wire logic dtack_n = vme_dtack_oe_n ? 1'b1 : vme_dtack_o;
    wire logic [31:0] bus = vme_data_oe_n ? noise : vme_data_o;
    initial
    begin
        vme_addr = 32'h00000000;
        vme_am = 6'h00;
        vme_as_n = 1'b1;
        vme_ds_n = 1'b1;
        vme_write_n = 1'b1;
        vme_data_i = 32'h00000000;
    end
    always @(posedge mclk) noise <= ~noise;
    task automatic cycle(input logic [31:0] a, input logic [5:0] am,
        input logic wr, input logic [31:0] wd, input int dly,
        output logic ack, output logic [31:0] rd);
        int n;
        @(posedge mclk);
        vme_addr <= a;
        vme_am <= am;
        vme_write_n <= !wr;
        vme_data_i <= wr ? wd : ~vme_data_i;
        vme_as_n <= 1'b0;
        repeat (dly) @(posedge mclk);
        vme_ds_n <= 1'b0;
        @(posedge mclk);
        for (n = 0; dtack_n !== 1'b0 && n < 30; n++)
            @(posedge mclk);
        ack = dtack_n === 1'b0;
        rd = bus;
        vme_as_n <= 1'b1;
        vme_ds_n <= 1'b1;
        vme_addr <= ~a;
        vme_data_i <= ~vme_data_i;
        for (n = 0; dtack_n !== 1'b1 && n < 10; n++)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask
endmodule

// File: vbad_decoder_tb.sv
// Self-checking bench for the base address decoder
`timescale 1ns/100ps
module vbad_decoder_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] vme_addr, vme_data_i, vme_data_o, local_wdata, avs_readdata;
    logic [5:0] vme_am;
    logic vme_as_n, vme_ds_n, vme_write_n, vme_data_oe_n, vme_dtack_o;
    logic vme_dtack_oe_n, local_start, local_write, mem_512mb;
    logic avs_waitrequest;
    logic [4:0] vme_ga_n = 5'h00;
    logic wide_addressing_jumper = 1'b1;
    logic slot_addressing_jumper = 1'b0, mem_size_jumper = 1'b0;
    logic [3:0] high_nibble_rotary_switch = 4'h3;
    logic [3:0] low_nibble_rotary_switch = 4'h8;
    logic [23:0] local_offset, hit_off;
    logic [11:0] key_pulse, last_key = 12'h000;
    logic local_done = 1'b0;
    logic [31:0] local_rdata = 32'h00000000;
    logic [31:0] hit_wd, starts = 32'h00000000;
    logic hit_wr;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    int failures = 0, checks_done = 0;
    always #50 mclk = ~mclk;
    vbad_decoder vbad_decoder_i (.mclk, .reset, .vme_addr, .vme_am, .vme_as_n,
        .vme_ds_n, .vme_write_n, .vme_ga_n, .vme_data_i, .vme_data_o,
        .vme_data_oe_n, .vme_dtack_o, .vme_dtack_oe_n, .wide_addressing_jumper,
        .slot_addressing_jumper, .mem_size_jumper, .high_nibble_rotary_switch,
        .low_nibble_rotary_switch, .local_start, .local_write, .local_offset,
        .local_wdata, .local_done, .local_rdata, .key_pulse, .mem_512mb,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest);
    vbad_vme_master vbad_vme_master_i (.mclk, .vme_addr, .vme_am, .vme_as_n,
        .vme_ds_n, .vme_write_n, .vme_data_i, .vme_data_o, .vme_data_oe_n,
        .vme_dtack_o, .vme_dtack_oe_n);
    // ----------------------------------------
    // Register map stand-in and monitors
    // ----------------------------------------
    always @(posedge mclk)
    begin
        local_done <= local_start;
        local_rdata <= {8'hc3, local_offset};
        if (local_start)
        begin
            hit_off <= local_offset;
            hit_wd <= local_wdata;
            hit_wr <= local_write;
            starts <= starts + 32'h1;
        end
        if (key_pulse != 12'h000)
            last_key <= key_pulse;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_sim;
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic avs(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge mclk);
        for (n = 0; avs_waitrequest !== 1'b0 && n < 20; n++)
            @(posedge mclk);
        if (n == 20)
            failures++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Read data echoes the offset
    task automatic vcyc(input logic [31:0] a, input logic [5:0] am,
        input logic wr, input logic exp_ack);
        logic ack;
        logic [31:0] rd;
        vbad_vme_master_i.cycle(a, am, wr, ~a, 1, ack, rd);
        chk({31'h0, ack}, {31'h0, exp_ack});
        if (exp_ack && !wr)
            chk(rd, {8'hc3, a[23:0]});
    endtask
    task automatic straps(input logic w, input logic s, input logic z,
        input logic [4:0] ga);
        @(posedge mclk);
        wide_addressing_jumper <= w;
        slot_addressing_jumper <= s;
        mem_size_jumper <= z;
        vme_ga_n <= ga;
        repeat (4) @(posedge mclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        avs(1'b0, vbad_pkg::REG_LAST_ADDR, 32'h0, d);
        chk(d, vbad_pkg::FACTORY_BASE);
        avs(1'b0, vbad_pkg::REG_CONTROL, 32'h0, d);
        chk(d, vbad_pkg::CONTROL_RST);
        avs(1'b0, vbad_pkg::REG_STATUS, 32'h0, d);
        chk(d, 32'h00000938);
        avs(1'b1, 8'h40, 32'hffffffff, d);
        avs(1'b0, 8'h40, 32'h0, d);
        chk(d, 32'h00000000);
    endtask
    task automatic t_factory;
        vcyc(32'h38000124, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b1);
        vcyc(32'h38fffffc, vbad_pkg::AM_A32_DATA_S, 1'b1, 1'b1);
        chk({8'h00, hit_off}, 32'h00fffffc);
        chk(hit_wd, ~32'h38fffffc);
        chk({31'h0, hit_wr}, 32'h1);
        vcyc(32'h39000000, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        vcyc(32'h28000000, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        vcyc(32'h1f000000, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
    endtask
    task automatic t_am;
        for (int i = 0; i < 64; i++)
            vcyc(32'h38000010, i[5:0], 1'b0, i[5:3] == 3'b001);
    endtask
    task automatic t_modes;
        logic [31:0] d;
        straps(1'b0, 1'b0, 1'b0, 5'h00);
        vcyc(32'h38000000, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        straps(1'b0, 1'b1, 1'b0, ~5'h18);
        vcyc(32'h18000000, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        straps(1'b1, 1'b1, 1'b1, ~5'h0b);
        avs(1'b0, vbad_pkg::REG_STATUS, 32'h0, d);
        chk(d, 32'h00000f38);
        chk({31'h0, mem_512mb}, 32'h1);
        vcyc(32'heb000040, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b1);
        vcyc(32'h0b000044, vbad_pkg::AM_A32_BLT_S, 1'b1, 1'b1);
        vcyc(32'h38000040, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        vcyc(32'h0a000040, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        straps(1'b1, 1'b0, 1'b0, 5'h00);
        chk({31'h0, mem_512mb}, 32'h0);
    endtask
    task automatic t_keys;
        logic [31:0] d, s0;
        for (int n = 0; n < 12; n++)
        begin
            s0 = starts;
            vcyc(32'h38000400 + 32'(4 * n), vbad_pkg::AM_A32_DATA_U, 1'b1,
                1'b1);
            chk({20'h0, last_key}, 32'h1 << n);
            chk(starts, s0);
        end
        avs(1'b0, vbad_pkg::REG_KEY_SEEN, 32'h0, d);
        chk(d, 32'h00000fff);
        avs(1'b1, vbad_pkg::REG_KEY_SEEN, 32'h00000fff, d);
        avs(1'b0, vbad_pkg::REG_KEY_SEEN, 32'h0, d);
        chk(d, 32'h00000000);
    endtask
    task automatic t_ctl;
        logic [31:0] d;
        avs(1'b1, vbad_pkg::REG_CONTROL, 32'h0, d);
        vcyc(32'h38000020, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b0);
        avs(1'b1, vbad_pkg::REG_CONTROL, 32'h1, d);
        vcyc(32'h38000020, vbad_pkg::AM_A32_DATA_U, 1'b0, 1'b1);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        t_regs;
        t_factory;
        t_am;
        t_modes;
        t_keys;
        t_ctl;
        end_sim;
    end
    // Run takes about 2800 cycles
    initial
    begin
        #2000000;
        failures++;
        end_sim;
    end
endmodule
